// [src/link_enhancement_control.v]
`timescale 1ns/10ps
`default_nettype none
`include "link_enhancement_regs.vh"

module link_enhancement_control #(
   parameter ADDR_WIDTH = 8
) (
   input  wire                  sys_clk,
   input  wire                  rst_b,
   input  wire                  clk_en,
   input  wire                  soft_reset,
   // Register port
   input  wire [ADDR_WIDTH-1:0] reg_addr,
   input  wire [31:0]           reg_wdata,
   input  wire                  reg_write,
   input  wire                  reg_read,
   output reg  [31:0]           reg_rdata,
   // Context from elsewhere in the link
   input  wire                  phy_enhancement_gate,
   input  wire                  retry_count_zero,
   input  wire [5:0]            cip_format_code,
   // Async transmit byte stream in (data, end of packet)
   input  wire [7:0]            tx_in_data,
   input  wire                  tx_in_last,
   input  wire                  tx_in_valid,
   output wire                  tx_in_ready,
   // Async transmit byte stream out towards the link
   output wire [7:0]            tx_out_data,
   output wire                  tx_out_last,
   output wire                  tx_out_valid,
   input  wire                  tx_out_ready,
   // Transmit status and effective controls
   output reg                   tx_underrun,
   output reg                   tx_store_forward,
   output reg                   tx_sending,
   output reg                   async_tx_in_order_only,
   output reg                   transport_stream_timestamp_fix,
   output reg                   video_stream_timestamp_fix,
   output reg                   priority_request_enable,
   output reg                   phy_accel_notify
);
   // ------------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------------
   reg        in_order;
   reg [1:0]  thresh_sel;
   reg        ts_fix;
   reg        vs_fix;
   reg        priority_en;
   reg        accel_en;
   wire       hit;
   wire [31:0] reg_value;

   assign hit = (reg_addr == `LEC_OFFSET);

   // global reset only
   // soft_reset is deliberately not used here: these fields survive it.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         in_order    <= 1'b0;
         thresh_sel  <= `THRESH_RESET;
         ts_fix      <= 1'b0;
         vs_fix      <= 1'b0;
         priority_en <= 1'b0;
         accel_en    <= 1'b0;
      end else if (clk_en && reg_write && hit) begin
         in_order    <= reg_wdata[`LEC_IN_ORDER_BIT];
         thresh_sel  <= reg_wdata[`LEC_THRESH_HI:`LEC_THRESH_LO];
         ts_fix      <= reg_wdata[`LEC_TS_FIX_BIT];
         vs_fix      <= reg_wdata[`LEC_VS_FIX_BIT];
         priority_en <= reg_wdata[`LEC_PRIORITY_BIT];
         accel_en    <= reg_wdata[`LEC_ACCEL_BIT];
      end
   end

   assign reg_value = {16'h0000, in_order, 1'b0, thresh_sel, 1'b0, ts_fix, 1'b0,
                       vs_fix, priority_en, 5'h00, accel_en, 1'b0};

   // Unmapped addresses read as zero
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (clk_en) begin
         reg_rdata <= (reg_read && hit) ? reg_value : 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------------
   // Effective controls
   // ------------------------------------------------------------------
   // Registered so downstream logic sees glitch-free levels.
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         async_tx_in_order_only         <= 1'b0;
         transport_stream_timestamp_fix <= 1'b0;
         video_stream_timestamp_fix     <= 1'b0;
         priority_request_enable        <= 1'b0;
         phy_accel_notify               <= 1'b0;
      end else if (clk_en) begin
         async_tx_in_order_only         <= phy_enhancement_gate & in_order;
         transport_stream_timestamp_fix <= phy_enhancement_gate & ts_fix &
                                           (cip_format_code == `FMT_TRANSPORT);
         video_stream_timestamp_fix     <= phy_enhancement_gate & vs_fix &
                                           (cip_format_code == `FMT_VIDEO);
         priority_request_enable        <= phy_enhancement_gate & priority_en;
         phy_accel_notify               <= phy_enhancement_gate & accel_en;
      end
   end

   // ------------------------------------------------------------------
   // Async transmit packet store and threshold control
   // ------------------------------------------------------------------
   localparam ST_FILL     = 3'b001;
   localparam ST_SEND     = 3'b010;
   localparam ST_DROP     = 3'b100;
   // Deep enough for the largest threshold; a longer packet would stall
   // store-and-forward mode, so sources must stay below this size.
   localparam STORE_DEPTH = 2048;

   reg  [2:0]  state;
   reg  [8:0]  store [0:STORE_DEPTH-1];
   reg  [10:0] wr_ptr;
   reg  [10:0] rd_ptr;
   reg  [11:0] level;
   reg  [11:0] eop_count;
   reg  [11:0] thresh_bytes;
   reg         retry_saf;
   wire [8:0]  buf_out;
   wire        buf_valid;
   wire        buf_ready;
   wire        saf_mode;
   wire        start_ok;
   wire        store_empty;
   wire        store_full;
   wire        wr_en;
   wire        rd_en;

   skid_buffer #(
      .WIDTH (9)
   ) u_buf (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .in_data   ({tx_in_last, tx_in_data}),
      .in_valid  (tx_in_valid),
      .in_ready  (tx_in_ready),
      .out_data  (buf_out),
      .out_valid (buf_valid),
      .out_ready (buf_ready)
   );

   always @* begin
      case (thresh_sel)
         `THRESH_1K7: thresh_bytes = `BYTES_1K7;
         `THRESH_1K:  thresh_bytes = `BYTES_1K;
         `THRESH_512: thresh_bytes = `BYTES_512;
         default:     thresh_bytes = 12'hfff;
      endcase
   end

   assign saf_mode = (thresh_sel == `THRESH_SAF) | retry_saf | retry_count_zero;

   assign start_ok = (eop_count != 12'h000) | (!saf_mode && level >= thresh_bytes);

   assign store_empty = (level == 12'h000);
   assign store_full  = (level == 12'h800);
   // A packet cut by an underrun is skipped up to its end, never stored
   assign buf_ready   = (state == ST_DROP) | !store_full;
   assign wr_en       = buf_valid & buf_ready & (state != ST_DROP);
   assign rd_en       = tx_out_valid & tx_out_ready;

   assign tx_out_valid = (state == ST_SEND) & !store_empty;
   assign tx_out_data  = store[rd_ptr][7:0];
   assign tx_out_last  = store[rd_ptr][8];

   // The store has no reset; the pointers and level say what is valid
   always @(posedge sys_clk) begin
      if (clk_en && wr_en) begin
         store[wr_ptr] <= buf_out;
      end
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr    <= 11'h000;
         rd_ptr    <= 11'h000;
         level     <= 12'h000;
         eop_count <= 12'h000;
      end else if (clk_en) begin
         if (wr_en) begin
            wr_ptr <= wr_ptr + 11'h001;
         end
         if (rd_en) begin
            rd_ptr <= rd_ptr + 11'h001;
         end
         level     <= level + {11'h000, wr_en} - {11'h000, rd_en};
         eop_count <= eop_count + {11'h000, wr_en & buf_out[8]} -
                      {11'h000, rd_en & tx_out_last};
      end
   end

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state            <= ST_FILL;
         retry_saf        <= 1'b0;
         tx_underrun      <= 1'b0;
         tx_store_forward <= 1'b0;
         tx_sending       <= 1'b0;
      end else if (clk_en) begin
         tx_underrun      <= 1'b0;
         tx_store_forward <= saf_mode;
         case (state)
            ST_FILL: begin
               tx_sending <= 1'b0;
               if (start_ok) begin
                  state      <= ST_SEND;
                  tx_sending <= 1'b1;
               end
            end
            ST_SEND: begin
               if (rd_en && tx_out_last) begin
                  state      <= ST_FILL;
                  tx_sending <= 1'b0;
                  retry_saf  <= 1'b0;
               end else if (store_empty && !wr_en) begin
                  tx_underrun <= 1'b1;
                  tx_sending  <= 1'b0;
                  retry_saf   <= 1'b1;
                  state       <= ST_DROP;
               end
            end
            ST_DROP: begin
               // The broken attempt's tail is discarded; the source re-sends it.
               if (buf_valid && buf_out[8]) begin
                  state <= ST_FILL;
               end
            end
            default: begin
               state <= ST_FILL;
            end
         endcase
      end
   end
endmodule // link_enhancement_control

`default_nettype wire

// [src/link_enhancement_regs.vh]
`ifndef LINK_ENHANCEMENT_REGS_VH
`define LINK_ENHANCEMENT_REGS_VH

// ----------------------------------------------------------------------
// Register offset (byte address on the register port)
// ----------------------------------------------------------------------
`define LEC_OFFSET          8'hf4
`define LEC_RESET_VALUE     32'h0000_1000
`define LEC_WRITE_MASK      32'h0000_b582

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LEC_IN_ORDER_BIT    15
`define LEC_THRESH_HI       13
`define LEC_THRESH_LO       12
`define LEC_TS_FIX_BIT      10
`define LEC_VS_FIX_BIT      8
`define LEC_PRIORITY_BIT    7
`define LEC_ACCEL_BIT       1

// ----------------------------------------------------------------------
// Threshold codes and byte counts
// ----------------------------------------------------------------------
`define THRESH_SAF          2'h0
`define THRESH_1K7          2'h1
`define THRESH_1K           2'h2
`define THRESH_512          2'h3
`define THRESH_RESET        2'h1
`define BYTES_1K7           12'h6c0
`define BYTES_1K            12'h400
`define BYTES_512           12'h200

// ----------------------------------------------------------------------
// Stream format codes
// ----------------------------------------------------------------------
`define FMT_TRANSPORT       6'h20
`define FMT_VIDEO           6'h00

`endif

// [src/skid_buffer.v]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------------
// Two-entry buffer, full throughput, registered ready
// ----------------------------------------------------------------------
module skid_buffer #(
   parameter WIDTH = 9
) (
   input  wire             sys_clk,
   input  wire             rst_b,
   input  wire             clk_en,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] slot0;
   reg [WIDTH-1:0] slot1;
   reg [1:0]       count;
   wire            push;
   wire            pop;

   assign in_ready  = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data  = slot0;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         slot0 <= {WIDTH{1'b0}};
         slot1 <= {WIDTH{1'b0}};
         count <= 2'h0;
      end else if (clk_en) begin
         if (pop) begin
            slot0 <= (count == 2'h2) ? slot1 : in_data;
         end else if (push && count == 2'h0) begin
            slot0 <= in_data;
         end
         if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
            slot1 <= in_data;
         end
         count <= count + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // skid_buffer

`default_nettype wire

// [tb/link_enhancement_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "link_enhancement_regs.vh"
// ----------------------------------------------------------
// Port checks on register reads, controls and tx path
// ----------------------------------------------------------
module link_enhancement_props (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic        phy_enhancement_gate,
   input wire logic        retry_count_zero,
   input wire logic [5:0]  cip_format_code,
   input wire logic [7:0]  tx_out_data,
   input wire logic        tx_out_last,
   input wire logic        tx_out_valid,
   input wire logic        tx_out_ready,
   input wire logic        tx_underrun,
   input wire logic        tx_store_forward,
   input wire logic        tx_sending,
   input wire logic        async_tx_in_order_only,
   input wire logic        transport_stream_timestamp_fix,
   input wire logic        video_stream_timestamp_fix,
   input wire logic        priority_request_enable,
   input wire logic        phy_accel_notify
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   wire any_on = async_tx_in_order_only | transport_stream_timestamp_fix |
                 video_stream_timestamp_fix | priority_request_enable | phy_accel_notify;
   sequence out_stalled;
      tx_out_valid && !tx_out_ready;
   endsequence
   sequence out_held;
      tx_out_valid && $stable(tx_out_data) && $stable(tx_out_last);
   endsequence
   chk_upper_zero: assert property (reg_rdata[31:16] == 16'h0)
      else $error("upper read data not zero");
   chk_rsvd_zero: assert property ((reg_rdata & ~`LEC_WRITE_MASK) == 32'h0)
      else $error("reserved read bits not zero");
   chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
      else $error("read data without a read");
   chk_gate_off: assert property (!$past(phy_enhancement_gate) |-> !any_on)
      else $error("enhancement active with gate low");
   chk_ts_format: assert property (transport_stream_timestamp_fix |->
      $past(cip_format_code) == `FMT_TRANSPORT) else $error("transport fix on wrong format");
   chk_vs_format: assert property (video_stream_timestamp_fix |->
      $past(cip_format_code) == `FMT_VIDEO) else $error("video fix on wrong format");
   chk_out_held: assert property (out_stalled |=> out_held)
      else $error("tx output changed while stalled");
   chk_out_sending: assert property (tx_out_valid |-> tx_sending)
      else $error("tx output outside send state");
   chk_retry_saf: assert property ($past(retry_count_zero) |-> tx_store_forward)
      else $error("zero retry count without store and forward");
   chk_underrun_saf: assert property (tx_underrun |-> ##[0:1] tx_store_forward)
      else $error("underrun without store and forward");
endmodule // link_enhancement_props
bind link_enhancement_control link_enhancement_props props_i (.*);
`default_nettype wire

// [tb/tx_link_sink.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------
// Link side of the tx stream: takes bytes, counts and sums packets
// ----------------------------------------------------------
module tx_link_sink (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        stall,
   input  wire logic [7:0]  tx_out_data,
   input  wire logic        tx_out_last,
   input  wire logic        tx_out_valid,
   input  wire logic        tx_underrun,
   output var  logic        tx_out_ready,
   output var  logic [7:0]  n_pkts,
   output var  logic [15:0] pkt_sum
);
   logic [15:0] acc;
   // Ready is registered, so a stall lands a cycle late as on a real link
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_out_ready <= 1'b0;
         n_pkts <= 8'h00;
         acc <= 16'h0000;
         pkt_sum <= 16'h0000;
      end else begin
         tx_out_ready <= !stall;
         // A cut packet is thrown away by the link
         if (tx_underrun)
            acc <= 16'h0000;
         if (tx_out_valid && tx_out_ready) begin
            acc <= tx_out_last ? 16'h0000 : acc + {8'h00, tx_out_data};
            if (tx_out_last) begin
               n_pkts <= n_pkts + 8'h01;
               pkt_sum <= acc + {8'h00, tx_out_data};
            end
         end
      end
   end
endmodule // tx_link_sink
`default_nettype wire

// [tb/link_enhancement_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
`include "link_enhancement_regs.vh"
module link_enhancement_control_bench;
   logic        sys_clk, rst_b, soft_reset, reg_write, reg_read, stall, clk_en;
   logic        phy_enhancement_gate, retry_count_zero, tx_in_last, tx_in_valid;
   logic [7:0]  reg_addr, tx_in_data;
   logic [31:0] reg_wdata;
   logic [5:0]  cip_format_code;
   wire  [31:0] reg_rdata;
   wire  [7:0]  tx_out_data, n_pkts;
   wire  [15:0] pkt_sum;
   wire         tx_in_ready, tx_out_last, tx_out_valid, tx_out_ready;
   wire         tx_underrun, tx_store_forward, tx_sending;
   wire  [4:0]  ctl;
   int          n_fail = 0, compares = 0, cyc = 0;
   link_enhancement_control dut (.*, .async_tx_in_order_only(ctl[4]),
      .transport_stream_timestamp_fix(ctl[3]), .video_stream_timestamp_fix(ctl[2]),
      .priority_request_enable(ctl[1]), .phy_accel_notify(ctl[0]));
   tx_link_sink sink (.*);
   // ----------------------------------------------------------
   // Bus, stream and compare helpers
   // ----------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge sys_clk);
      reg_write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      @(negedge sys_clk);
      chk(reg_rdata, exp);
      @(posedge sys_clk);
   endtask
   // Ready is sampled mid-cycle; it only moves on the rising edge
   task automatic feed(input int n, input bit eop);
      logic r;
      for (int i = 0; i < n; i++) begin
         tx_in_data <= i[7:0];
         tx_in_last <= eop && i == n - 1;
         tx_in_valid <= 1'b1;
         do begin
            @(negedge sys_clk);
            r = tx_in_ready;
            @(posedge sys_clk);
         end while (r !== 1'b1);
      end
      tx_in_valid <= 1'b0;
      tx_in_last <= 1'b0;
   endtask
   task automatic look(input logic exp);
      @(negedge sys_clk);
      chk(tx_sending, exp);
      @(posedge sys_clk);
   endtask
   // Byte sum of a packet that feed sends in n bytes, counted from zero
   function automatic logic [15:0] sum_to(input int n);
      logic [15:0] s;
      s = 16'h0000;
      for (int i = 0; i < n; i++) s = s + {8'h00, i[7:0]};
      return s;
   endfunction
   task automatic wait_pkt(input logic [7:0] p, input logic [15:0] s);
      for (int i = 0; i < 1000 && n_pkts !== p; i++) @(posedge sys_clk);
      chk(n_pkts, p);
      chk(pkt_sum, s);
   endtask
   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_regs;
      rdchk(`LEC_OFFSET, `LEC_RESET_VALUE);
      wr(`LEC_OFFSET, 32'hffff_ffff);
      wr(8'hf8, 32'h0000_0000);
      // Clock enable low: the write must not land
      clk_en <= 1'b0;
      wr(`LEC_OFFSET, 32'h0000_0000);
      clk_en <= 1'b1;
      rdchk(`LEC_OFFSET, `LEC_WRITE_MASK);
      rdchk(8'hf8, 32'h0000_0000);
      soft_reset <= 1'b1;
      @(posedge sys_clk);
      soft_reset <= 1'b0;
      rdchk(`LEC_OFFSET, `LEC_WRITE_MASK);
      rst_b <= 1'b0;
      @(posedge sys_clk);
      rst_b <= 1'b1;
      rdchk(`LEC_OFFSET, `LEC_RESET_VALUE);
      $display("t_regs done");
   endtask
   task automatic t_ctl;
      // all five enables set, threshold code left at 1K7
      wr(`LEC_OFFSET, 32'h0000_9582);
      for (int g = 0; g < 2; g++) begin
         for (int k = 0; k < 3; k++) begin
            phy_enhancement_gate <= g[0];
            cip_format_code <= k == 0 ? `FMT_TRANSPORT : k == 1 ? `FMT_VIDEO : 6'h3f;
            repeat (2) @(posedge sys_clk);
            @(negedge sys_clk);
            chk(ctl, {g[0], g[0] && k == 0, g[0] && k == 1, g[0], g[0]});
            @(posedge sys_clk);
         end
      end
      $display("t_ctl done");
   endtask
   task automatic t_saf;
      wr(`LEC_OFFSET, 32'h0000_0000);
      feed(6, 0);
      look(1'b0);
      stall <= 1'b1;
      feed(1, 1);
      repeat (8) @(posedge sys_clk);
      stall <= 1'b0;
      wait_pkt(8'h01, sum_to(6));
      $display("t_saf done");
   endtask
   task automatic t_thr;
      logic       u;
      logic [7:0] p;
      u = 1'b0;
      wr(`LEC_OFFSET, 32'h0000_3000);
      feed(500, 0);
      look(1'b0);
      feed(20, 0);
      look(1'b1);
      // The store drains its 512-odd bytes before it runs dry
      repeat (600) begin
         @(negedge sys_clk);
         u = u | (tx_underrun === 1'b1);
      end
      chk(u, 1'b1);
      chk(tx_store_forward, 1'b1);
      @(posedge sys_clk);
      feed(1, 1);
      p = n_pkts;
      @(posedge sys_clk);
      feed(600, 0);
      look(1'b0);
      feed(1, 1);
      wait_pkt(p + 8'h01, sum_to(600));
      retry_count_zero <= 1'b1;
      feed(520, 0);
      look(1'b0);
      feed(1, 1);
      wait_pkt(p + 8'h02, sum_to(520));
      retry_count_zero <= 1'b0;
      $display("t_thr done");
   endtask
   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Run needs about 3500 cycles; the ceiling leaves wide margin
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test;
      end
   end
   initial begin
      rst_b = 1'b0;
      {soft_reset, reg_write, reg_read, stall, tx_in_last, tx_in_valid} = 6'h00;
      clk_en = 1'b1;
      {phy_enhancement_gate, retry_count_zero} = 2'h0;
      {reg_addr, tx_in_data, reg_wdata, cip_format_code} = 54'h0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs;
      t_ctl;
      t_saf;
      t_thr;
      end_of_test;
   end
endmodule // link_enhancement_control_bench
`default_nettype wire
